/* File: hw/wsw_top.v */
// The Wishbone slave port and the address map were left to the implementer.
`include "wsw_map.vh"

module wsw_top #(
    parameter WDT_W    = 16,
    parameter RC_DIV   = 4,
    parameter POWER_UP_TIMER_CYC = 8000000
) (
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Configuration word
    input  wire        cfg_programmed_i,
    input  wire        cfg_watchdog_enable_i,
    input  wire [2:0]  cfg_osc_source_i,
    input  wire [4:0]  cfg_primary_osc_i,
    // CPU events and wake sources
    input  wire        watchdog_clear_instr_i,
    input  wire        power_save_instr_i,
    input  wire        power_save_mode_i,
    input  wire        irq_wake_i,
    input  wire        por_i,
    input  wire        brown_out_reset_i,
    input  wire        external_pin_reset_i,
    // Oscillator and supervisor status
    input  wire        lp_keep_in_sleep_i,
    input  wire        pll_lock_i,
    input  wire        bor_enable_i,
    input  wire        lvd_enable_i,
    // Clock and power control
    output wire        cpu_clk_en_o,
    output wire        periph_clk_en_o,
    output wire        osc_run_o,
    output wire        low_power_rc_clock_o,
    output wire        clk_monitor_en_o,
    output wire        bor_active_o,
    output wire        lvd_active_o,
    output reg  [2:0]  wake_osc_o,
    output reg         device_reset_o
);

    // Power states; settling stages follow Sleep in this order
    localparam [2:0] ST_RUN  = 3'h0;
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_SLP  = 3'h2;
    localparam [2:0] ST_POR  = 3'h3;
    localparam [2:0] ST_POWER_UP_TIMER = 3'h4;
    localparam [2:0] ST_OST  = 3'h5;
    localparam [2:0] ST_LOCK = 3'h6;

    // Wide constants are cut to the timer width on purpose
    localparam [31:0] POWER_ON_DELAY_W  = `WSW_POWER_ON_DELAY_CYC;
    localparam [31:0] PLL_LOCK_DELAY_W = `WSW_PLL_LOCK_DELAY_CYC;
    localparam [31:0] OST_W   = `WSW_OST_CYC;
    localparam [31:0] POWER_UP_TIMER_W  = POWER_UP_TIMER_CYC;
    localparam [31:0] DIV_W   = RC_DIV - 1;

    // Timer is 24 bits: the power-up count must stay below 2**24
    localparam [23:0] POWER_ON_DELAY_C  = POWER_ON_DELAY_W[23:0];
    localparam [23:0] PLL_LOCK_DELAY_C = PLL_LOCK_DELAY_W[23:0];
    localparam [23:0] OST_C   = OST_W[23:0];
    localparam [23:0] POWER_UP_TIMER_C  = POWER_UP_TIMER_W[23:0];
    localparam [7:0]  DIV_C   = DIV_W[7:0];

    // Sequencer, watchdog and register state

    reg  [2:0]       state_q;
    reg  [23:0]      tmr_q;
    reg  [2:0]       osc_q;
    reg              lp_kept_q;
    reg              cfg_en_q;
    reg              soft_watchdog_enable_q;
    reg              watchdog_timeout_flag_q;
    reg              swen_q;
    reg  [2:0]       current_osc_select_q;
    reg  [7:0]       div_q;
    reg  [WDT_W-1:0] wdt_q;
    reg              slp_seen_q;
    reg              idl_seen_q;
    reg  [31:0]      rd_word;

    wire wdt_en;
    wire rc_tick;
    wire wdt_ovf;
    wire wb_req;
    wire wb_wr;
    wire any_rst;
    // Decoded strobes
    wire wr_reset_control_reg;
    wire wr_osc;
    wire wake_req;

    // Fast wake sources need only the power-on delay
    // Low-power crystal is fast only when it was kept in Sleep
    function fast_osc;
        input [2:0] o;
        begin
            fast_osc = (o == `WSW_OSC_EXT) || (o == `WSW_OSC_FRC) ||
                       (o == `WSW_OSC_LOW_POWER_RC_CLOCK) || (o == `WSW_OSC_ERC);
        end
    endfunction

    // Oscillator chosen by the configuration fields
    function [2:0] cfg_osc;
        input [2:0] cfg_osc_source;
        input [4:0] cfg_primary_osc;
        begin
            if (cfg_osc_source == `WSW_FOS_PRIMARY)
                cfg_osc = cfg_primary_osc[2:0];
            else
                cfg_osc = cfg_osc_source;
        end
    endfunction

    // Awake states: CPU or peripherals clocked, overflow resets
    function awake_st;
        input [2:0] s;
        begin
            awake_st = (s == ST_RUN) || (s == ST_IDLE);
        end
    endfunction

    // Wake-up states: clock held while the timers run out
    function settling_st;
        input [2:0] s;
        begin
            settling_st = (s == ST_POR) || (s == ST_POWER_UP_TIMER) ||
                          (s == ST_OST) || (s == ST_LOCK);
        end
    endfunction

    // Config enable forces the watchdog on; else the soft bit
    assign wdt_en  = cfg_en_q | soft_watchdog_enable_q;
    assign any_rst = por_i | brown_out_reset_i | external_pin_reset_i;
    assign wb_req  = cyc_i & stb_i;
    assign wb_wr   = wb_req & we_i & ack_o & sel_i[0];

    // Write strobes per register, taken at the ack edge
    assign wr_reset_control_reg  = wb_wr & (adr_i == `WSW_ADR_RESET_CONTROL_REG);
    assign wr_osc   = wb_wr & (adr_i == `WSW_ADR_OSC);
    // Any of these ends Sleep
    assign wake_req = irq_wake_i | any_rst | wdt_ovf;

    // RC oscillator runs whenever the watchdog needs it, asleep or not
    assign low_power_rc_clock_o = wdt_en;
    assign rc_tick = wdt_en & (div_q == DIV_C);
    // A clear on the very tick of overflow still saves the device;
    // the count restarts instead of rolling into a reset
    assign wdt_ovf = rc_tick & (&wdt_q) & ~watchdog_clear_instr_i;

    // Gating follows the power state; monitor idles while asleep
    // Idle keeps peripherals clocked; only the CPU stops
    assign cpu_clk_en_o     = (state_q == ST_RUN);
    assign periph_clk_en_o  = (state_q == ST_RUN) |
                              (state_q == ST_IDLE);
    assign osc_run_o        = (state_q != ST_SLP) | lp_kept_q;
    assign clk_monitor_en_o = (state_q != ST_SLP);
    // Supervisors are not touched by the power state
    assign bor_active_o     = bor_enable_i;
    assign lvd_active_o     = lvd_enable_i;

    // Config bit latched at reset release; erased parts read one
    // A new config word only takes effect at the next reset
    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg_en_q <= cfg_programmed_i ? cfg_watchdog_enable_i
                                         : `WSW_ERASED_WDTEN;
        end
    end

    // RC divider: stands in for the separate watchdog oscillator
    // It stops while disabled, so the first tick is a full period
    always @(posedge clk_i) begin
        if (rst_i || !wdt_en || div_q == DIV_C) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // Watchdog counter, width set by parameter
    // Disabled watchdog holds zero, so enabling starts a full period
    always @(posedge clk_i) begin
        if (rst_i || !wdt_en) begin
            wdt_q <= {WDT_W{1'b0}};
        end else if (watchdog_clear_instr_i) begin
            wdt_q <= {WDT_W{1'b0}};
        end else if (rc_tick) begin
            wdt_q <= wdt_q + {{(WDT_W-1){1'b0}}, 1'b1};
        end
    end

    // Read mux; unmapped offsets read as zero
    always @* begin
        rd_word = 32'h0000_0000;
        case (adr_i)
        `WSW_ADR_RESET_CONTROL_REG: rd_word = {26'h0, soft_watchdog_enable_q, watchdog_timeout_flag_q,
                                  slp_seen_q, idl_seen_q, 2'h0};
        `WSW_ADR_OSC:  rd_word = {28'h0, swen_q, current_osc_select_q};
        `WSW_ADR_WDT:  rd_word = {{(32-WDT_W){1'b0}}, wdt_q};
        default:       rd_word = 32'h0000_0000;
        endcase
    end

    // Wishbone: ack one cycle after request, write at the ack edge
    // Back-to-back requests are not taken: ack needs a gap
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= wb_req & ~ack_o;
            // Data latched at the request edge, shown with ack
            if (wb_req & ~ack_o & ~we_i)
                dat_o <= rd_word;
        end
    end

    // Software bits of the reset control and oscillator registers
    // Oscillator field only steers wake-up while switching is on
    always @(posedge clk_i) begin
        if (rst_i) begin
            soft_watchdog_enable_q <= 1'b0;
            swen_q   <= 1'b0;
            current_osc_select_q   <= `WSW_RST_OSC;
        end else begin
            // Soft enable only matters while the config bit is clear
            if (wr_reset_control_reg)
                soft_watchdog_enable_q <= dat_i[`WSW_RESET_CONTROL_REG_SOFT_WATCHDOG_ENABLE];
            if (wr_osc) begin
                swen_q <= dat_i[`WSW_OSC_SWEN];
                current_osc_select_q <= dat_i[2:0];
            end
        end
    end

    // Status flags: hardware set beats a software clear
    // Slept and idled flags tell software where the last wake came from
    always @(posedge clk_i) begin
        if (rst_i) begin
            watchdog_timeout_flag_q     <= 1'b0;
            slp_seen_q <= 1'b0;
            idl_seen_q <= 1'b0;
        end else begin
            if (wr_reset_control_reg) begin
                watchdog_timeout_flag_q     <= dat_i[`WSW_RESET_CONTROL_REG_WATCHDOG_TIMEOUT_FLAG];
                slp_seen_q <= dat_i[`WSW_RESET_CONTROL_REG_SLEEP];
                idl_seen_q <= dat_i[`WSW_RESET_CONTROL_REG_IDLE];
            end
            // Flag marks a watchdog reset; an overflow while the clock
            // is still held on wake-up resets nothing, so it is not shown
            if (wdt_ovf && awake_st(state_q))
                watchdog_timeout_flag_q <= 1'b1;
            if (wdt_ovf && state_q == ST_SLP)
                watchdog_timeout_flag_q <= 1'b0;
            if (state_q == ST_SLP)
                slp_seen_q <= 1'b1;
            if (state_q == ST_IDLE)
                idl_seen_q <= 1'b1;
        end
    end

    // Power-state sequencer with wake-up delays
    always @(posedge clk_i) begin
        if (rst_i) begin
            // Reset returns to run with the default oscillator
            state_q        <= ST_RUN;
            tmr_q          <= 24'h000000;
            osc_q          <= `WSW_RST_OSC;
            lp_kept_q      <= 1'b0;
            wake_osc_o     <= `WSW_RST_OSC;
            device_reset_o <= 1'b0;
        end else begin
            device_reset_o <= 1'b0;
            // Shared timer; each wake stage restarts it from zero
            tmr_q          <= tmr_q + 24'h000001;
            case (state_q)
            // Running: overflow resets, the instruction saves power
            ST_RUN: begin
                if (wdt_ovf) begin
                    device_reset_o <= 1'b1;
                end else if (power_save_instr_i) begin
                    // Only the instruction enters a saving state
                    if (power_save_mode_i == `WSW_PS_SLEEP) begin
                        state_q   <= ST_SLP;
                        lp_kept_q <= lp_keep_in_sleep_i &
                                     (osc_q == `WSW_OSC_LP);
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
            end
            // Idle: overflow still resets, a wake goes straight to run
            ST_IDLE: begin
                if (wdt_ovf) begin
                    device_reset_o <= 1'b1;
                    state_q        <= ST_RUN;
                end else if (irq_wake_i | any_rst) begin
                    state_q <= ST_RUN;
                end
            end
            ST_SLP: begin
                // Overflow here wakes rather than resets
                if (wake_req) begin
                    state_q <= ST_POR;
                    tmr_q   <= 24'h000000;
                    // Power-on and brown-out take the oscillator from
                    // config; others take the switched field, or config without switching
                    if (por_i | brown_out_reset_i)
                        osc_q <= cfg_osc(cfg_osc_source_i,
                                         cfg_primary_osc_i);
                    else if (swen_q)
                        osc_q <= current_osc_select_q;
                    else
                        osc_q <= cfg_osc(cfg_osc_source_i,
                                         cfg_primary_osc_i);
                end
            end
            // Power-on delay applies to every wake source
            // Kept low-power crystal skips the longer stages
            ST_POR: begin
                wake_osc_o <= osc_q;
                if (tmr_q >= POWER_ON_DELAY_C - 24'h000001) begin
                    tmr_q <= 24'h000000;
                    if (fast_osc(osc_q))
                        state_q <= ST_RUN;
                    else if (osc_q == `WSW_OSC_LP && lp_kept_q)
                        state_q <= ST_RUN;
                    else
                        state_q <= ST_POWER_UP_TIMER;
                end
            end
            // Power-up delay, crystal sources only
            ST_POWER_UP_TIMER: begin
                if (tmr_q >= POWER_UP_TIMER_C - 24'h000001) begin
                    tmr_q   <= 24'h000000;
                    state_q <= ST_OST;
                end
            end
            ST_OST: begin
                // Clock held until the crystal has settled
                if (tmr_q >= OST_C - 24'h000001) begin
                    tmr_q <= 24'h000000;
                    if (osc_q == `WSW_OSC_XPLL)
                        state_q <= ST_LOCK;
                    else
                        state_q <= ST_RUN;
                end
            end
            ST_LOCK: begin
                // Lock must be seen after the lock delay has run
                // A lost lock restarts the wait; no upper bound is set
                if (!pll_lock_i)
                    tmr_q <= 24'h000000;
                else if (tmr_q >= PLL_LOCK_DELAY_C - 24'h000001)
                    state_q <= ST_RUN;
            end
            // Unused codes fall back to run
            default: begin
                state_q <= ST_RUN;
            end
            endcase
            // Outside Sleep and wake-up, follow the switched clock
            if (!settling_st(state_q) && state_q != ST_SLP && swen_q)
                osc_q <= current_osc_select_q;
        end
    end

endmodule // wsw_top

/* File: hw/wsw_map.vh */
// How it works
// - Watchdog counts on its own RC tick, independent of system clock gating
// - Configuration enable bit at 1 forces the watchdog on for good
// - Erased configuration reads the watchdog enable bit as 1
// - Enabled watchdog counts to overflow; overflow while awake resets device
// - Clear instruction restarts the watchdog count from zero
// - Overflow during Sleep wakes the device instead of resetting it
// - Wake by watchdog overflow clears the time-out status bit
// - With configuration bit 0, reset control bit 5 enables the watchdog
// - Only the power-save instruction enters Sleep or Idle, per its operand
// - Sleep stops CPU and peripheral clocks and shuts on-chip oscillator
// - Sleep keeps RC clock while watchdog runs; clock monitor is off
// - Brown-out and low-voltage detection stay active through Sleep
// - Sleep ends on enabled interrupt, any reset, or watchdog overflow
// - Wake takes configuration fields; with switching, current-oscillator field
// - Power-on or brown-out wake picks oscillator from configuration fields
// - Crystal wake waits power-on, power-up, start-up timer, and PLL lock for PLL
// - External, fast RC, low-power RC, external RC wake waits power-on only
// - Low-power crystal kept running in Sleep wakes after power-on only
`ifndef WSW_MAP_VH
`define WSW_MAP_VH
// Register byte offsets
`define WSW_ADR_RESET_CONTROL_REG      4'h0
`define WSW_ADR_OSC       4'h4
`define WSW_ADR_WDT       4'h8
// Reset control fields
`define WSW_RESET_CONTROL_REG_SOFT_WATCHDOG_ENABLE   5
`define WSW_RESET_CONTROL_REG_WATCHDOG_TIMEOUT_FLAG     4
`define WSW_RESET_CONTROL_REG_SLEEP    3
`define WSW_RESET_CONTROL_REG_IDLE     2
// Oscillator register fields
`define WSW_OSC_SWEN      3
// Reset values
`define WSW_ERASED_WDTEN  1'b1
`define WSW_RST_OSC       3'h0
// Oscillator codes
`define WSW_OSC_FRC       3'h0
`define WSW_OSC_EXT       3'h1
`define WSW_OSC_ERC       3'h2
`define WSW_OSC_LOW_POWER_RC_CLOCK      3'h3
`define WSW_OSC_XTAL      3'h4
`define WSW_OSC_XPLL      3'h5
`define WSW_OSC_LP        3'h6
`define WSW_FOS_PRIMARY   3'h7
// Power-save operand
`define WSW_PS_SLEEP      1'b0
// Timing
`define WSW_CLK_MHZ       125
`define WSW_POWER_ON_DELAY_NS       10000
`define WSW_PLL_LOCK_DELAY_NS      20000
`define WSW_POWER_ON_DELAY_CYC  ((`WSW_POWER_ON_DELAY_NS * `WSW_CLK_MHZ + 999) / 1000)
`define WSW_PLL_LOCK_DELAY_CYC ((`WSW_PLL_LOCK_DELAY_NS * `WSW_CLK_MHZ + 999) / 1000)
`define WSW_OST_CYC       1024
`endif

/* File: tb/wsw_top_monitor.sv */
module wsw_top_monitor (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire ack_o,
    input wire power_save_instr_i,
    input wire power_save_mode_i,
    input wire lp_keep_in_sleep_i,
    input wire bor_enable_i,
    input wire lvd_enable_i,
    input wire cpu_clk_en_o,
    input wire periph_clk_en_o,
    input wire osc_run_o,
    input wire clk_monitor_en_o,
    input wire bor_active_o,
    input wire lvd_active_o,
    input wire device_reset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Requests only count while the CPU runs
    sequence s_sleep;
        power_save_instr_i && !power_save_mode_i && cpu_clk_en_o;
    endsequence
    sequence s_idle;
        power_save_instr_i && power_save_mode_i && cpu_clk_en_o;
    endsequence
    a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing after request");
    a_sleep_gates: assert property (
        s_sleep |=> (!cpu_clk_en_o && !periph_clk_en_o) [*2])
        else $error("clocks still on in sleep");
    a_sleep_osc_off: assert property (
        s_sleep ##0 !lp_keep_in_sleep_i |=> !osc_run_o)
        else $error("oscillator still on in sleep");
    a_sleep_mon_off: assert property (s_sleep |=> !clk_monitor_en_o)
        else $error("clock monitor on in sleep");
    a_idle_keeps: assert property (
        s_idle |=> !cpu_clk_en_o && periph_clk_en_o)
        else $error("idle clock gating wrong");
    a_detect_live: assert property (
        bor_active_o == bor_enable_i && lvd_active_o == lvd_enable_i)
        else $error("detector enable not followed");
    a_reset_pulse: assert property (device_reset_o |=> !device_reset_o)
        else $error("device reset longer than one cycle");
    a_reset_awake: assert property (
        device_reset_o |-> $past(periph_clk_en_o))
        else $error("device reset raised while asleep");
endmodule // wsw_top_monitor

bind wsw_top wsw_top_monitor u_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
    .power_save_instr_i, .power_save_mode_i, .lp_keep_in_sleep_i,
    .bor_enable_i, .lvd_enable_i, .cpu_clk_en_o, .periph_clk_en_o,
    .osc_run_o, .clk_monitor_en_o, .bor_active_o, .lvd_active_o,
    .device_reset_o);

/* File: tb/wsw_top_bench.sv */
`include "wsw_map.vh"

module wsw_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        w;
        logic [3:0]  a;
        logic [31:0] d;
    } wsw_row_t;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic        we_i = 1'b0, ack_o, cpu_clk_en_o, device_reset_o;
    logic        cfg_programmed_i = 1'b1, cfg_watchdog_enable_i = 1'b0;
    logic        watchdog_clear_instr_i = 1'b0, power_save_instr_i = 1'b0;
    logic        power_save_mode_i = 1'b0, irq_wake_i = 1'b0, por_i = 1'b0;
    logic        pll_lock_i = 1'b1, bor_enable_i = 1'b0;
    logic        low_power_rc_clock_o;
    logic        brown_out_reset_i = 1'b0, external_pin_reset_i = 1'b0;
    logic        lp_keep_in_sleep_i = 1'b0, lvd_enable_i = 1'b1;
    logic [3:0]  sel_i = 4'hF;
    logic [3:0]  adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic [2:0]  cfg_osc_source_i = 3'h0, wake_osc_o;
    logic [4:0]  cfg_primary_osc_i = 5'h00;
    int          n_checks = 0, n_mismatch = 0, t;
    // Reads carry the expected value in d
    wsw_row_t    rows [6] = '{'{1'b0, `WSW_ADR_WDT, 32'h0},
        '{1'b1, `WSW_ADR_OSC, 32'hD}, '{1'b0, `WSW_ADR_OSC, 32'hD},
        '{1'b1, 4'hC, 32'hFFFFFFFF}, '{1'b0, 4'hC, 32'h0},
        '{1'b0, `WSW_ADR_RESET_CONTROL_REG, 32'h0}};

    // Short counts keep the run brief
    wsw_top #(.WDT_W(10), .RC_DIV(2), .POWER_UP_TIMER_CYC(100)) uut (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .cfg_programmed_i, .cfg_watchdog_enable_i,
        .cfg_osc_source_i, .cfg_primary_osc_i, .watchdog_clear_instr_i,
        .power_save_instr_i, .power_save_mode_i, .irq_wake_i, .por_i,
        .brown_out_reset_i, .external_pin_reset_i,
        .lp_keep_in_sleep_i, .pll_lock_i, .bor_enable_i,
        .lvd_enable_i, .cpu_clk_en_o, .periph_clk_en_o(),
        .osc_run_o(), .low_power_rc_clock_o, .clk_monitor_en_o(),
        .bor_active_o(), .lvd_active_o(), .wake_osc_o, .device_reset_o);

    always #4 clk_i = ~clk_i;

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask

    // One classic cycle; ack and data taken at the same edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        chk("bus ack", 32'h1, ack_o);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Sleep, then wake by src: 0 timer, 1 interrupt, 2 power-on
    task automatic nap(input logic [1:0] src);
        power_save_instr_i <= 1'b1;
        power_save_mode_i <= `WSW_PS_SLEEP;
        @(posedge clk_i);
        power_save_instr_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        irq_wake_i <= src[0];
        por_i <= src[1];
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (cpu_clk_en_o !== 1'b1 && t < 9000);
        irq_wake_i <= 1'b0;
        por_i <= 1'b0;
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Whole run is about 16.5k cycles; this limit is well beyond it
    initial begin
        #400us;
        n_mismatch++;
        give_verdict;
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk("row read", rows[i].d, q);
        end
        // Masked byte lane leaves the oscillator register alone
        sel_i <= 4'hE;
        bus(1'b1, `WSW_ADR_OSC, 32'h0);
        sel_i <= 4'hF;
        bus(1'b0, `WSW_ADR_OSC, 32'h0);
        chk("masked write", 32'hD, q);
        // Fast clock restarts after the short delay only
        bus(1'b1, `WSW_ADR_OSC, 32'hB);
        nap(2'd1);
        chk("fast wake time", 32'h1, t >= 1250 && t <= 1260);
        chk("wake osc", `WSW_OSC_LOW_POWER_RC_CLOCK, wake_osc_o);
        bus(1'b1, `WSW_ADR_OSC, 32'hD);
        nap(2'd1);
        chk("pll wake time", 32'h1, t >= 4874 && t <= 4884);
        chk("wake osc", `WSW_OSC_XPLL, wake_osc_o);
        // Power-on wake ignores the switched clock
        bor_enable_i <= 1'b1;
        lvd_enable_i <= 1'b0;
        cfg_osc_source_i <= `WSW_FOS_PRIMARY;
        cfg_primary_osc_i <= 5'h02;
        nap(2'd2);
        chk("por wake osc", `WSW_OSC_ERC, wake_osc_o);
        bus(1'b1, `WSW_ADR_RESET_CONTROL_REG, 32'h20);
        repeat (20) @(posedge clk_i);
        bus(1'b0, `WSW_ADR_WDT, 32'h0);
        chk("count running", 32'h1, q != 0);
        watchdog_clear_instr_i <= 1'b1;
        @(posedge clk_i);
        watchdog_clear_instr_i <= 1'b0;
        bus(1'b0, `WSW_ADR_WDT, 32'h0);
        chk("count cleared", 32'h1, q < 4);
        chk("rc clock on", 32'h1, low_power_rc_clock_o);
        t = 0;
        while (device_reset_o !== 1'b1 && t < 2200) begin
            @(posedge clk_i);
            t++;
        end
        chk("overflow reset", 32'h1, device_reset_o);
        bus(1'b0, `WSW_ADR_RESET_CONTROL_REG, 32'h0);
        chk("flag after reset", 32'h30, q);
        // Overflow in sleep wakes and clears the flag
        nap(2'd0);
        bus(1'b0, `WSW_ADR_RESET_CONTROL_REG, 32'h0);
        chk("flag after wake", 32'h28, q);
        power_save_instr_i <= 1'b1;
        power_save_mode_i <= 1'b1;
        @(posedge clk_i);
        power_save_instr_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk("idle cpu clock", 32'h0, cpu_clk_en_o);
        // Erased, then programmed on: software cannot stop it
        for (int k = 0; k < 2; k++) begin
            cfg_programmed_i <= k[0];
            cfg_watchdog_enable_i <= k[0];
            rst_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
            @(posedge clk_i);
            bus(1'b1, `WSW_ADR_RESET_CONTROL_REG, 32'h0);
            repeat (20) @(posedge clk_i);
            bus(1'b0, `WSW_ADR_WDT, 32'h0);
            chk("forced count", 32'h1, q != 0);
        end
        give_verdict;
    end
endmodule // wsw_top_bench
